// file: src/dbr_regs.sv
/*
 * Debug identification and status/control registers, core and scan views.
 * Assumes core requests and scan requests are single-cycle strobes on i_clk,
 * already synchronised by the scan transport.
 */
`include "dbr_defines.svh"

// What this block does
// - ID bits 31:28 read watch pairs minus one
// - ID bits 27:24 read break pairs minus one
// - ID bits 23:20 read context pairs minus one
// - ID bits 19:16 version, 15:8 reserved
// - ID variant mirrors main ID bits 23:20
// - ID revision mirrors main ID bits 3:0
// - Scan side reads ID while core runs
// - ID privileged read ok, writes undefined
// - User ID read undefined when lock bit set
// - Status privileged full, user read-only unlocked
// - Inbound full set by scan, cleared core
// - No inbound write accepted while full unless the core reads it in the same cycle
// - Outbound full set by core, cleared scan
// - Monitor enable: core writes, scan reads
// - Halt select: scan writes, core reads
// - Debug exception when monitor selected, enabled
// - User lock resets clear, traps user accesses
module dbr_regs
    import dbr_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int WATCH_PAIRS = `DBR_WATCH_PAIRS,
    parameter int BREAK_PAIRS = `DBR_BREAK_PAIRS,
    parameter int CTX_PAIRS = `DBR_CTX_PAIRS
) (
    input wire logic i_clk,                 // System clock, 25 MHz
    input wire logic i_reset,               // Synchronous reset, high
    input wire logic [31:0] i_main_id,      // Main processor ID value
    input wire logic i_cp_valid,            // Core coprocessor access strobe
    input wire logic i_cp_write,            // 1 = write, 0 = read
    input wire logic i_cp_user,             // Access made in user mode
    input wire logic [2:0] i_cp_op1,        // Opcode_1 selector
    input wire logic [3:0] i_cp_crn,        // CRn selector
    input wire logic [3:0] i_cp_crm,        // CRm selector
    input wire logic [2:0] i_cp_op2,        // Opcode_2 selector
    input wire logic [31:0] i_cp_wdata,     // Core write data
    input wire logic i_cp_xfer_rd,          // Core reads inbound transfer word
    input wire logic i_cp_xfer_wr,          // Core writes outbound transfer word
    input wire logic i_scan_valid,          // Scan access strobe
    input wire logic i_scan_write,          // Scan write, 0 = read
    input wire logic [1:0] i_scan_sel,      // Scan register selector
    input wire logic [31:0] i_scan_wdata,   // Scan write data
    output logic [31:0] o_cp_rdata,         // Core read data
    output logic o_cp_done,                 // Core access completed
    output logic o_cp_undef,                // Undefined-instruction trap
    output logic [31:0] o_scan_rdata,       // Scan read data
    output logic o_scan_done,               // Scan access completed
    output logic [31:0] o_inbound_data,     // Inbound word for the core
    output logic o_debug_exc_enable,        // Monitor mode selected and enabled
    output logic o_halt_mode,               // Halting mode selected
    output logic o_user_lock                // User channel access disabled
);
    // Fixed identification fields, counts stored minus one
    localparam logic [3:0] WATCH_CODE = 4'(WATCH_PAIRS - 1);
    localparam logic [3:0] BREAK_CODE = 4'(BREAK_PAIRS - 1);
    localparam logic [3:0] CTX_CODE = 4'(CTX_PAIRS - 1);

    // Status/control state
    logic mon_en;      // Monitor enable, core owned
    logic halt_sel;    // Mode select, scan owned
    logic user_lock;   // User access lock, core owned
    wire logic in_full;   // Inbound word full
    wire logic out_full;  // Outbound word full
    wire logic [WIDTH-1:0] in_word;   // Inbound stored word
    wire logic [WIDTH-1:0] out_word;  // Outbound stored word

    // Identification word assembled from constants and main ID
    wire logic [31:0] id_word;
    assign id_word = {WATCH_CODE, BREAK_CODE, CTX_CODE,
                      `DBR_DEBUG_VERSION, `DBR_RESERVED_FILL,
                      i_main_id[`DBR_MAIN_VAR_MSB:`DBR_MAIN_VAR_LSB],
                      i_main_id[`DBR_MAIN_REV_MSB:`DBR_MAIN_REV_LSB]};

    // Status word, reserved bits read zero
    wire logic [31:0] sc_word;
    assign sc_word = {1'b0, in_full, out_full, 13'h0000, mon_en, halt_sel,
                      1'b0, user_lock, 12'h000};

    // Core selector decode
    wire logic sel_id;
    wire logic sel_sc;
    assign sel_id = (i_cp_op1 == `DBR_OP1_ID) && (i_cp_crn == `DBR_CRN_ID)
                    && (i_cp_crm == `DBR_CRM_ID) && (i_cp_op2 == `DBR_OP2_ID);
    assign sel_sc = (i_cp_op1 == `DBR_OP1_SC) && (i_cp_crn == `DBR_CRN_SC)
                    && (i_cp_crm == `DBR_CRM_SC) && (i_cp_op2 == `DBR_OP2_SC);

    // Access kind of the core request
    dbr_acc_t cp_acc;
    assign cp_acc = !i_cp_valid ? DBR_ACC_NONE
                    : (i_cp_write ? DBR_ACC_WRITE : DBR_ACC_READ);

    // Trap decision: ID writes always, user reads when locked, user SC writes
    wire logic user_blocked;
    wire logic id_trap;
    wire logic sc_trap;
    wire logic xfer_trap;
    wire logic cp_trap;
    assign user_blocked = i_cp_user && user_lock;
    assign id_trap = sel_id && ((cp_acc == DBR_ACC_WRITE)
                     || ((cp_acc == DBR_ACC_READ) && user_blocked));
    assign sc_trap = sel_sc && (((cp_acc == DBR_ACC_WRITE) && i_cp_user)
                     || ((cp_acc == DBR_ACC_READ) && user_blocked));
    assign xfer_trap = (i_cp_xfer_rd || i_cp_xfer_wr) && user_blocked;
    assign cp_trap = id_trap || sc_trap || xfer_trap;

    // Core read data select; unmapped selectors read zero
    wire logic [31:0] next_cp_rdata;
    assign next_cp_rdata = (cp_acc != DBR_ACC_READ || cp_trap) ? 32'h0000_0000
                           : sel_id ? id_word
                           : sel_sc ? sc_word : 32'h0000_0000;

    // Core-side effects allowed only when not trapped
    wire logic sc_core_wr;
    wire logic in_core_rd;
    wire logic out_core_wr;
    assign sc_core_wr = sel_sc && (cp_acc == DBR_ACC_WRITE) && !cp_trap;
    assign in_core_rd = i_cp_xfer_rd && !xfer_trap;
    assign out_core_wr = i_cp_xfer_wr && !xfer_trap;

    // Scan-side decode; ID readable with no core involvement
    wire logic scan_rd;
    wire logic scan_wr;
    wire logic in_scan_wr;
    wire logic out_scan_rd;
    wire logic sc_scan_wr;
    assign scan_rd = i_scan_valid && !i_scan_write;
    assign scan_wr = i_scan_valid && i_scan_write;
    assign in_scan_wr = scan_wr && (i_scan_sel == `DBR_SCAN_SEL_IN);
    assign out_scan_rd = scan_rd && (i_scan_sel == `DBR_SCAN_SEL_OUT);
    assign sc_scan_wr = scan_wr && (i_scan_sel == `DBR_SCAN_SEL_SC);

    // Scan read data select
    wire logic [31:0] next_scan_rdata;
    assign next_scan_rdata = !scan_rd ? 32'h0000_0000
        : (i_scan_sel == `DBR_SCAN_SEL_ID) ? id_word
        : (i_scan_sel == `DBR_SCAN_SEL_SC) ? sc_word
        : (i_scan_sel == `DBR_SCAN_SEL_OUT) ? out_word[31:0] : 32'h0000_0000;

    // Inbound word: scan fills, core drains
    dbr_xfer_word #(
        .WIDTH(WIDTH)
    ) u_inbound (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_wr(in_scan_wr),        // Blocked inside while full, unless drained in the same cycle
        .i_data(i_scan_wdata[WIDTH-1:0]),
        .i_rd(in_core_rd),
        .o_data(in_word),
        .o_full(in_full)
    );

    // Outbound word: core fills, scan drains
    dbr_xfer_word #(
        .WIDTH(WIDTH)
    ) u_outbound (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_wr(out_core_wr),
        .i_data(i_cp_wdata[WIDTH-1:0]),
        .i_rd(out_scan_rd),
        .o_data(out_word),
        .o_full(out_full)
    );

    // Control bits, each with one writer; full flags ignore writes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mon_en <= `DBR_RST_BIT;
            halt_sel <= `DBR_RST_BIT;
            user_lock <= `DBR_RST_BIT;
        end else begin
            if (sc_core_wr) begin
                mon_en <= i_cp_wdata[`DBR_SC_MON_EN];
                user_lock <= i_cp_wdata[`DBR_SC_USER_LOCK];
            end
            if (sc_scan_wr) begin
                halt_sel <= i_scan_wdata[`DBR_SC_HALT_SEL];
            end
        end
    end

    // Core answer registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_cp_rdata <= 32'h0000_0000;
            o_cp_done <= 1'b0;
            o_cp_undef <= 1'b0;
        end else begin
            o_cp_rdata <= next_cp_rdata;
            o_cp_done <= i_cp_valid || i_cp_xfer_rd || i_cp_xfer_wr;
            o_cp_undef <= cp_trap;
        end
    end

    // Scan answer registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_scan_rdata <= 32'h0000_0000;
            o_scan_done <= 1'b0;
        end else begin
            o_scan_rdata <= next_scan_rdata;
            o_scan_done <= i_scan_valid;
        end
    end

    // Mode and lock outputs registered from the next control state, inbound data from the stored word
    wire logic next_mon_en;
    wire logic next_halt_sel;
    assign next_mon_en = sc_core_wr ? i_cp_wdata[`DBR_SC_MON_EN] : mon_en;
    assign next_halt_sel = sc_scan_wr ? i_scan_wdata[`DBR_SC_HALT_SEL] : halt_sel;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_debug_exc_enable <= 1'b0;
            o_halt_mode <= 1'b0;
            o_user_lock <= 1'b0;
            o_inbound_data <= 32'h0000_0000;
        end else begin
            o_debug_exc_enable <= next_mon_en && !next_halt_sel;
            o_halt_mode <= next_halt_sel;
            o_user_lock <= sc_core_wr ? i_cp_wdata[`DBR_SC_USER_LOCK] : user_lock;
            o_inbound_data <= in_word[31:0];
        end
    end
endmodule // dbr_regs

// file: common/dbr_defines.svh
/*
 * Offsets, field positions, reset values and fixed codes for the debug
 * identification and status/control register block.
 * Assumes inclusion by bare name from the design and simulation files.
 */
`ifndef DBR_DEFINES_SVH
`define DBR_DEFINES_SVH

// Coprocessor selector values for the two registers (opcode_1, CRn, CRm, opcode_2)
`define DBR_OP1_ID 3'h0
`define DBR_CRN_ID 4'h0
`define DBR_CRM_ID 4'h0
`define DBR_OP2_ID 3'h0
`define DBR_OP1_SC 3'h0
`define DBR_CRN_SC 4'h0
`define DBR_CRM_SC 4'h1
`define DBR_OP2_SC 3'h0

// Scan-side register selectors
`define DBR_SCAN_SEL_ID 2'h0
`define DBR_SCAN_SEL_SC 2'h1
`define DBR_SCAN_SEL_IN 2'h2
`define DBR_SCAN_SEL_OUT 2'h3

// Identification fields
`define DBR_ID_WATCH_MSB 31
`define DBR_ID_WATCH_LSB 28
`define DBR_ID_BREAK_MSB 27
`define DBR_ID_BREAK_LSB 24
`define DBR_ID_CTX_MSB 23
`define DBR_ID_CTX_LSB 20
`define DBR_ID_VER_MSB 19
`define DBR_ID_VER_LSB 16
`define DBR_ID_VAR_MSB 7
`define DBR_ID_VAR_LSB 4
`define DBR_ID_REV_MSB 3
`define DBR_ID_REV_LSB 0
`define DBR_WATCH_PAIRS 2
`define DBR_BREAK_PAIRS 6
`define DBR_CTX_PAIRS 2
`define DBR_DEBUG_VERSION 4'h1
`define DBR_RESERVED_FILL 8'h00

// Main ID source positions
`define DBR_MAIN_VAR_MSB 23
`define DBR_MAIN_VAR_LSB 20
`define DBR_MAIN_REV_MSB 3
`define DBR_MAIN_REV_LSB 0

// Status/control bit positions
`define DBR_SC_IN_FULL 30
`define DBR_SC_OUT_FULL 29
`define DBR_SC_MON_EN 15
`define DBR_SC_HALT_SEL 14
`define DBR_SC_USER_LOCK 12

// Reset values
`define DBR_RST_BIT 1'h0

`endif

// file: common/dbr_pkg.sv
/*
 * Types shared by the debug register block.
 * Assumes the defines header is on the include path.
 */
package dbr_pkg;
    // Access kind decoded from a coprocessor request
    typedef enum logic [1:0] {
        DBR_ACC_NONE,
        DBR_ACC_READ,
        DBR_ACC_WRITE
    } dbr_acc_t;
endpackage : dbr_pkg

// file: src/dbr_xfer_word.sv
/*
 * One transfer data word with a full flag and single-cycle set/clear.
 * Assumes the writer and reader sit on the same clock.
 */
module dbr_xfer_word #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk,              // System clock
    input wire logic i_reset,            // Synchronous reset, high
    input wire logic i_wr,               // Write strobe from filling side
    input wire logic [WIDTH-1:0] i_data, // Write data
    input wire logic i_rd,               // Read strobe from draining side
    output logic [WIDTH-1:0] o_data,     // Stored word, registered
    output logic o_full                  // Full flag, registered
);
    // Write lands only when empty, or when drained in the same cycle
    wire logic wr_ok;
    wire logic next_full;
    assign wr_ok = i_wr && (!o_full || i_rd);
    // Set beats clear so a write meeting a read is never lost
    assign next_full = wr_ok ? 1'b1 : (i_rd ? 1'b0 : o_full);

    // Flag and data update in the access cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_full <= 1'b0;
            o_data <= '0;
        end else begin
            o_full <= next_full;
            if (wr_ok) begin
                o_data <= i_data;
            end
        end
    end
endmodule // dbr_xfer_word

// file: sim/dbr_regs_assertions.sv
/* Checker for the debug register block, bound onto its top module.
   Assumes one clock domain and a synchronous active-high reset. */
`include "dbr_defines.svh"
module dbr_regs_assertions #(
    parameter int WATCH_PAIRS = 2,
    parameter int BREAK_PAIRS = 6,
    parameter int CTX_PAIRS = 2
) (
    input wire logic i_clk, // Clock
    input wire logic i_reset, // Reset
    input wire logic [31:0] i_main_id, // Main ID
    input wire logic i_cp_valid, // Core strobe
    input wire logic i_cp_write, // Core write
    input wire logic i_cp_user, // User mode
    input wire logic [2:0] i_cp_op1, // Selector
    input wire logic [3:0] i_cp_crn, // Selector
    input wire logic [3:0] i_cp_crm, // Selector
    input wire logic [2:0] i_cp_op2, // Selector
    input wire logic [31:0] i_cp_wdata, // Core data
    input wire logic i_cp_xfer_rd, // Inbound read
    input wire logic i_cp_xfer_wr, // Outbound write
    input wire logic i_scan_valid, // Scan strobe
    input wire logic i_scan_write, // Scan write
    input wire logic [1:0] i_scan_sel, // Scan selector
    input wire logic [31:0] o_cp_rdata, // Core read data
    input wire logic o_cp_done, // Core done
    input wire logic o_cp_undef, // Trap
    input wire logic o_scan_done, // Scan done
    input wire logic o_debug_exc_enable, // Exception enable
    input wire logic o_halt_mode, // Halt select
    input wire logic o_user_lock // User lock
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Decoded selectors, shared by several properties
    wire logic [13:0] sel = {i_cp_op1, i_cp_crn, i_cp_crm, i_cp_op2};
    wire logic is_id = sel == {`DBR_OP1_ID, `DBR_CRN_ID, `DBR_CRM_ID, `DBR_OP2_ID};
    wire logic is_sc = sel == {`DBR_OP1_SC, `DBR_CRN_SC, `DBR_CRM_SC, `DBR_OP2_SC};
    wire logic cp_any = i_cp_valid | i_cp_xfer_rd | i_cp_xfer_wr;
    wire logic sc_wr = i_scan_valid & i_scan_write & (i_scan_sel == `DBR_SCAN_SEL_SC);
    wire logic lock_wr = i_cp_valid & i_cp_write & !i_cp_user & is_sc & i_cp_wdata[12];
    wire logic [7:0] mirror = {i_main_id[23:20], i_main_id[3:0]};
    AST_CP_DONE: assert property (cp_any |=> o_cp_done)
        else $error("core access not completed");
    AST_DONE_CAUSE: assert property (o_cp_done |-> $past(cp_any))
        else $error("core done without request");
    AST_ID_FIELDS: assert property (i_cp_valid && !i_cp_write && !i_cp_user && is_id |=>
        o_cp_rdata[31:16] == {4'(WATCH_PAIRS - 1), 4'(BREAK_PAIRS - 1), 4'(CTX_PAIRS - 1),
        `DBR_DEBUG_VERSION} && o_cp_rdata[7:0] == $past(mirror))
        else $error("identification value wrong");
    AST_ID_WRITE: assert property (i_cp_valid && i_cp_write && is_id |=> o_cp_undef)
        else $error("identification write not trapped");
    AST_USER_LOCK: assert property (i_cp_valid && i_cp_user && !i_cp_write && o_user_lock
        && (is_id || is_sc) |=> o_cp_undef) else $error("locked user read not trapped");
    AST_USER_WR: assert property (i_cp_valid && i_cp_user && i_cp_write && is_sc |=> o_cp_undef)
        else $error("user status write not trapped");
    AST_EXC: assert property (o_halt_mode |-> !o_debug_exc_enable)
        else $error("exception enabled in halting mode");
    AST_HALT_SRC: assert property ($changed(o_halt_mode) |-> $past(sc_wr) || $past(i_reset))
        else $error("halt select changed without scan write");
    AST_LOCK_SRC: assert property ($rose(o_user_lock) |-> $past(lock_wr))
        else $error("lock set without privileged write");
    AST_SCAN_DONE: assert property (i_scan_valid |=> o_scan_done)
        else $error("scan access not completed");
    // Main scenarios reached
    cover property (i_cp_valid && is_id ##1 o_cp_undef);
    cover property ($rose(o_halt_mode));
    cover property ($rose(o_debug_exc_enable));
endmodule // dbr_regs_assertions

// file: sim/dbr_dbg_model.sv
/* External debugger model driving the scan access port.
   Assumes the block answers each one-cycle strobe on the next cycle. */
module dbr_dbg_model (
    input wire logic i_clk, // System clock
    output logic o_valid = 1'b0, // Scan strobe
    output logic o_write = 1'b0, // Scan write
    output logic [1:0] o_sel = 2'h0, // Scan selector
    output logic [31:0] o_wdata = 32'h0 // Scan write data
);
    timeunit 1ns;
    timeprecision 1ns;
    // One scan access; data bus shows inverted junk once released
    task automatic xfer(input logic wr, input logic [1:0] sel, input logic [31:0] wd);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_write <= wr;
        o_sel <= sel;
        o_wdata <= wd;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_wdata <= ~wd;
        #1;
    endtask
endmodule // dbr_dbg_model

// file: sim/tb.sv
/* Self-checking bench for the debug register block.
   Assumes a 25 MHz clock and answers one cycle after each strobe. */
`include "dbr_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [13:0] SID = {`DBR_OP1_ID, `DBR_CRN_ID, `DBR_CRM_ID, `DBR_OP2_ID};
    localparam logic [13:0] SSC = {`DBR_OP1_SC, `DBR_CRN_SC, `DBR_CRM_SC, `DBR_OP2_SC};
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic cp_valid = 1'b0, cp_write = 1'b0, cp_user = 1'b0, xfer_rd = 1'b0, xfer_wr = 1'b0;
    logic [13:0] cp_sel = 14'h0000;
    logic [31:0] main_id = 32'h0, cp_wdata = 32'h0, seed = 32'h4B347745, d;
    logic scan_valid, scan_write, cp_done, cp_undef, scan_done, exc_en, halt, lock;
    logic [1:0] scan_sel;
    logic [31:0] scan_wdata, cp_rdata, scan_rdata, in_data;
    int fails = 0, samples_checked = 0, cycles = 0;
    dbr_dbg_model u_dbg (.i_clk(i_clk), .o_valid(scan_valid), .o_write(scan_write),
        .o_sel(scan_sel), .o_wdata(scan_wdata));
    dbr_regs DUT (.i_clk(i_clk), .i_reset(i_reset), .i_main_id(main_id), .i_cp_valid(cp_valid),
        .i_cp_write(cp_write), .i_cp_user(cp_user), .i_cp_op1(cp_sel[13:11]),
        .i_cp_crn(cp_sel[10:7]), .i_cp_crm(cp_sel[6:3]), .i_cp_op2(cp_sel[2:0]),
        .i_cp_wdata(cp_wdata), .i_cp_xfer_rd(xfer_rd), .i_cp_xfer_wr(xfer_wr),
        .i_scan_valid(scan_valid), .i_scan_write(scan_write), .i_scan_sel(scan_sel),
        .i_scan_wdata(scan_wdata), .o_cp_rdata(cp_rdata), .o_cp_done(cp_done),
        .o_cp_undef(cp_undef), .o_scan_rdata(scan_rdata), .o_scan_done(scan_done),
        .o_inbound_data(in_data), .o_debug_exc_enable(exc_en), .o_halt_mode(halt),
        .o_user_lock(lock));
    always #20 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_id(input logic [31:0] m);
        return {4'(`DBR_WATCH_PAIRS - 1), 4'(`DBR_BREAK_PAIRS - 1), 4'(`DBR_CTX_PAIRS - 1),
            `DBR_DEBUG_VERSION, 8'h00, m[23:20], m[3:0]};
    endfunction
    // Flags as {inbound full, outbound full, monitor, halt, lock}
    function automatic logic [31:0] exp_sc(input logic [4:0] f);
        return {1'b0, f[4], f[3], 13'h0, f[2], f[1], 1'b0, f[0], 12'h0};
    endfunction
    task automatic close_out();
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Core strobe {access, inbound read, outbound write}, then trap check
    task automatic cp(input logic [2:0] stb, input logic wr, input logic usr,
        input logic [13:0] sel, input logic [31:0] wd, input logic undef);
        @(posedge i_clk);
        {cp_valid, xfer_rd, xfer_wr} <= stb;
        cp_write <= wr;
        cp_user <= usr;
        cp_sel <= sel;
        cp_wdata <= wd;
        @(posedge i_clk);
        {cp_valid, xfer_rd, xfer_wr} <= 3'h0;
        #1;
        chk("undef", {31'h0, undef}, {31'h0, cp_undef});
        chk("done", 32'h1, {31'h0, cp_done});
    endtask
    // Hang guard, well above the length of the sequence
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        cp(3'h4, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("status", exp_sc(5'h00), cp_rdata);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            @(posedge i_clk);
            main_id <= seed;
            cp(3'h4, 1'b0, k[0], SID, 32'h0, 1'b0);
            chk("id", exp_id(seed), cp_rdata);
            u_dbg.xfer(1'b0, `DBR_SCAN_SEL_ID, seed);
            chk("id_scan", exp_id(seed), scan_rdata);
            chk("scan_done", 32'h1, {31'h0, scan_done});
            cp(3'h4, 1'b1, k[1], SID, seed, 1'b1);
        end
        // Each side tries to write the other's mode bit too
        for (int m = 0; m < 4; m++) begin
            cp(3'h4, 1'b1, 1'b0, SSC, {16'h0, m[0], !m[1], 14'h0}, 1'b0);
            u_dbg.xfer(1'b1, `DBR_SCAN_SEL_SC, {16'h0, !m[0], m[1], 14'h0});
            cp(3'h4, 1'b0, 1'b1, SSC, 32'h0, 1'b0);
            chk("status", exp_sc({2'h0, m[0], m[1], 1'b0}), cp_rdata);
            chk("exc", {31'h0, m[0] & !m[1]}, {31'h0, exc_en});
        end
        cp(3'h4, 1'b1, 1'b0, SSC, 32'h00009000, 1'b0);
        chk("lock", 32'h1, {31'h0, lock});
        cp(3'h4, 1'b0, 1'b1, SID, 32'h0, 1'b1);
        cp(3'h4, 1'b0, 1'b1, SSC, 32'h0, 1'b1);
        cp(3'h4, 1'b0, 1'b0, SID, 32'h0, 1'b0);
        cp(3'h4, 1'b1, 1'b1, SSC, 32'h0, 1'b1);
        cp(3'h4, 1'b1, 1'b0, SSC, 32'h0, 1'b0);
        cp(3'h4, 1'b1, 1'b1, SSC, 32'h00009000, 1'b1);
        d = lfsr(seed);
        u_dbg.xfer(1'b1, `DBR_SCAN_SEL_IN, d);
        cp(3'h4, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("status", exp_sc(5'h12), cp_rdata);
        u_dbg.xfer(1'b1, `DBR_SCAN_SEL_IN, ~d);
        cp(3'h2, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        @(posedge i_clk);
        #1;
        chk("inbound", d, in_data);
        // Refill meeting a drain in one cycle: the new word lands, flag stays set
        u_dbg.xfer(1'b1, `DBR_SCAN_SEL_IN, d);
        fork
            u_dbg.xfer(1'b1, `DBR_SCAN_SEL_IN, ~d);
            cp(3'h2, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        join
        cp(3'h4, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("status", exp_sc(5'h12), cp_rdata);
        cp(3'h2, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("inbound", ~d, in_data);
        seed = lfsr(d);
        cp(3'h1, 1'b0, 1'b0, SSC, seed, 1'b0);
        cp(3'h4, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("status", exp_sc(5'h0A), cp_rdata);
        u_dbg.xfer(1'b0, `DBR_SCAN_SEL_OUT, 32'h0);
        chk("outbound", seed, scan_rdata);
        cp(3'h4, 1'b0, 1'b0, SSC, 32'h0, 1'b0);
        chk("status", exp_sc(5'h02), cp_rdata);
        close_out();
    end
endmodule // tb
bind dbr_regs dbr_regs_assertions #(.WATCH_PAIRS(WATCH_PAIRS), .BREAK_PAIRS(BREAK_PAIRS),
    .CTX_PAIRS(CTX_PAIRS)) u_chk (.*);
